// ==== rtl/bcr_pkg.sv ====
// constants and types of the boot configuration register block
package bcr_pkg;

  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [1:0] BCR_IDX_SELECT = 2'h0;
  localparam logic [1:0] BCR_IDX_BUS = 2'h1;
  localparam logic [1:0] BCR_IDX_DBG = 2'h2;
  localparam logic [1:0] BCR_IDX_SPARE = 2'h3;
  localparam logic [31:0] BCR_ADDR_SELECT = 32'h0000_0000;
  localparam logic [31:0] BCR_ADDR_BUS = 32'h0000_0004;
  localparam logic [31:0] BCR_ADDR_DBG = 32'h0000_0008;
  localparam logic [31:0] BCR_ADDR_SPARE = 32'h0000_000C;

  // ---------------------------------------------------------------
  // startup load
  // ---------------------------------------------------------------
  localparam logic [7:0] BCR_BOOT_ADDR_FIRST = 8'h20;
  localparam logic [7:0] BCR_BOOT_ADDR_LAST = 8'h23;
  localparam logic [15:0] BCR_UPPER_FIXED = 16'hFFFB;
  localparam logic [31:0] BCR_CFG_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // field positions, startup select byte
  // ---------------------------------------------------------------
  localparam int BCR_B0_MAP_HI = 5;
  localparam int BCR_B0_MAP_LO = 4;
  localparam int BCR_B0_INTERNAL_BOOT_SEL = 3;
  localparam int BCR_B0_IPROG = 2;

  // ---------------------------------------------------------------
  // field positions, bus config byte
  // ---------------------------------------------------------------
  localparam int BCR_B1_DUAL_CS = 7;
  localparam int BCR_B1_FULL_TRACE = 6;
  localparam int BCR_B1_TRACE_OFF = 5;
  localparam int BCR_B1_POWER_SAVE = 4;
  localparam int BCR_B1_WIDTH = 3;
  localparam int BCR_B1_ASYNC = 2;
  localparam int BCR_B1_PIN_MODE_HI = 1;
  localparam int BCR_B1_MULTI_PIN = 0;

  // ---------------------------------------------------------------
  // field positions, debug and reset byte
  // ---------------------------------------------------------------
  localparam int BCR_B2_HALT = 7;
  localparam int BCR_B2_PULSE_LEN = 6;
  localparam int BCR_B2_TEST_TOG = 2;
  localparam int BCR_B2_ACC_WIDTH = 0;

  // ---------------------------------------------------------------
  // counts in clock cycles (one crystal period per clock)
  // ---------------------------------------------------------------
  localparam logic [11:0] BCR_PULSE_SHORT_CYC = 12'h008;
  localparam logic [11:0] BCR_PULSE_LONG_CYC = 12'h800;
  localparam logic [6:0] BCR_CS_SLOW_PHASES = 7'h7F;

  typedef enum logic [1:0] {
    BCR_ST_FETCH,
    BCR_ST_WAIT,
    BCR_ST_DONE
  } bcr_load_state_t;

endpackage : bcr_pkg

// ==== rtl/bcr_reset_pulse.sv ====
// reset pulse generator for the reset output pin
`timescale 1ns/1ps
module bcr_reset_pulse
  import bcr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic int_reset_req,
  input wire logic test_pin,
  input wire logic pulse_short_sel,
  output logic reset_out_n
);

  // ---------------------------------------------------------------
  // pulse length and counter
  // ---------------------------------------------------------------
  logic busy_reg;
  logic por_reg;
  logic [11:0] cnt_reg;
  logic [11:0] len;

  always_comb begin
    if (!test_pin) begin
      len = BCR_PULSE_LONG_CYC;
    end else if (por_reg || pulse_short_sel) begin
      len = BCR_PULSE_SHORT_CYC;
    end else begin
      len = BCR_PULSE_LONG_CYC;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_reg <= 1'b1;
      cnt_reg <= 12'h000;
    end else if (busy_reg) begin
      if (cnt_reg == len - 12'h001) begin
        busy_reg <= 1'b0;
        cnt_reg <= 12'h000;
      end else begin
        cnt_reg <= cnt_reg + 12'h001;
      end
    end else if (int_reset_req) begin
      busy_reg <= 1'b1;
      cnt_reg <= 12'h000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_reg <= 1'b1;
    end else if (busy_reg && cnt_reg == len - 12'h001) begin
      por_reg <= 1'b0;
    end
  end

  assign reset_out_n = !busy_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_low8;
    !reset_out_n [*8];
  endsequence

  a_short_pulse: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ($fell(reset_out_n) && test_pin && pulse_short_sel && !por_reg)
      ##1 (test_pin && pulse_short_sel) [*7]
      |-> ##1 reset_out_n)
    else $error("short reset pulse not eight cycles");

  a_long_pulse: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ($fell(reset_out_n) && !test_pin) |-> s_low8)
    else $error("long reset pulse ended early");

endmodule : bcr_reset_pulse

// ==== rtl/bcr_top.sv ====
// boot configuration register with ahb-lite access and startup load
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module bcr_top
  import bcr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [7:0] boot_mem_addr,
  output logic boot_mem_req,
  input wire logic [7:0] boot_mem_data,
  input wire logic boot_mem_ack,
  output logic core_run,
  input wire logic int_reset_req,
  input wire logic test_pin,
  output logic reset_out_n,
  input wire logic debug_mode,
  output logic debug_timer_halt,
  input wire logic active_mode,
  input wire logic second_test_pin,
  output logic [1:0] bus_mode_sel,
  output logic multi_pin_port_mode,
  output logic program_access_16,
  output logic dual_chip_select,
  output logic second_cs_used,
  input wire logic cpu_slow,
  input wire logic access_active,
  output logic chip_select_first_n,
  output logic bus_pins_pulldown,
  output logic bus_16bit,
  output logic bus_async,
  output logic latch_transparent,
  output logic data_drive_always,
  output logic trace_enable,
  output logic trace_grounded,
  output logic trace_analyzer,
  output logic map_ram_zero,
  output logic map_rom_zero,
  output logic map_boot_zero,
  output logic boot_internal,
  output logic boot_external,
  output logic boot_disabled,
  output logic program_internal
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] force_dbg(input logic [7:0] b,
                                           input logic wide16);
    logic [7:0] r;
    r = b;
    if (wide16) begin
      r[BCR_B2_HALT] = 1'b1;
      r[BCR_B2_PULSE_LEN] = 1'b1;
      r[BCR_B2_ACC_WIDTH] = 1'b1;
      r[BCR_B2_TEST_TOG] = 1'b0;
    end
    return r;
  endfunction : force_dbg

  function automatic logic [2:0] addr_decode(input logic [31:0] a);
    logic [2:0] r;
    r = 3'h4;
    if (a == BCR_ADDR_SELECT) begin
      r = {1'b0, BCR_IDX_SELECT};
    end else if (a == BCR_ADDR_BUS) begin
      r = {1'b0, BCR_IDX_BUS};
    end else if (a == BCR_ADDR_DBG) begin
      r = {1'b0, BCR_IDX_DBG};
    end else if (a == BCR_ADDR_SPARE) begin
      r = {1'b0, BCR_IDX_SPARE};
    end
    return r;
  endfunction : addr_decode

  // ---------------------------------------------------------------
  // configuration storage
  // ---------------------------------------------------------------
  logic [31:0] cfg_reg;
  logic [31:0] cfg_eff;
  bcr_load_state_t state_reg;
  logic [1:0] idx_reg;
  logic wr_pend_reg;
  logic [1:0] wr_idx_reg;
  logic [2:0] dec;
  logic take;
  logic wide16;

  assign wide16 = cfg_reg[8 + BCR_B1_WIDTH];
  assign cfg_eff = {cfg_reg[31:24], force_dbg(cfg_reg[23:16], wide16),
                    cfg_reg[15:0]};

  // ---------------------------------------------------------------
  // startup load sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= BCR_ST_FETCH;
      idx_reg <= 2'h0;
    end else begin
      case (state_reg)
        BCR_ST_FETCH: begin
          state_reg <= BCR_ST_WAIT;
        end
        BCR_ST_WAIT: begin
          if (boot_mem_ack) begin
            if (idx_reg == BCR_IDX_SPARE) begin
              state_reg <= BCR_ST_DONE;
            end else if (idx_reg == BCR_IDX_BUS &&
                         boot_mem_data[BCR_B1_WIDTH]) begin
              state_reg <= BCR_ST_DONE;
            end else begin
              idx_reg <= idx_reg + 2'h1;
              state_reg <= BCR_ST_FETCH;
            end
          end
        end
        default: begin
          state_reg <= BCR_ST_DONE;
        end
      endcase
    end
  end

  assign boot_mem_req = (state_reg == BCR_ST_WAIT);
  assign boot_mem_addr = BCR_BOOT_ADDR_FIRST + {6'h00, idx_reg};
  assign core_run = (state_reg == BCR_ST_DONE);

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  assign dec = addr_decode(haddr);
  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 2'h0;
    end else begin
      wr_pend_reg <= take && hwrite && !dec[2] &&
                     dec[1:0] != BCR_IDX_SPARE;
      wr_idx_reg <= dec[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      if (dec[2]) begin
        hrdata <= 32'h0000_0000;
      end else begin
        hrdata <= {24'h00_0000, cfg_eff[dec[1:0]*8 +: 8]};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= BCR_CFG_RESET;
    end else if (state_reg == BCR_ST_WAIT && boot_mem_ack) begin
      cfg_reg[idx_reg*8 +: 8] <= boot_mem_data;
      if (idx_reg == BCR_IDX_BUS && boot_mem_data[BCR_B1_WIDTH]) begin
        cfg_reg[31:16] <= BCR_UPPER_FIXED;
      end
    end else if (wr_pend_reg && core_run) begin
      cfg_reg[wr_idx_reg*8 +: 8] <= hwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // reset pulse output
  // ---------------------------------------------------------------
  bcr_reset_pulse u_pulse (
    .hclk(hclk),
    .hresetn(hresetn),
    .int_reset_req(int_reset_req),
    .test_pin(test_pin),
    .pulse_short_sel(cfg_eff[16 + BCR_B2_PULSE_LEN]),
    .reset_out_n(reset_out_n)
  );

  // ---------------------------------------------------------------
  // debug timer halt
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_timer_halt <= 1'b0;
    end else begin
      debug_timer_halt <= debug_mode && cfg_eff[16 + BCR_B2_HALT];
    end
  end

  // ---------------------------------------------------------------
  // first chip select, slow mode duty
  // ---------------------------------------------------------------
  logic [6:0] phase_reg;
  logic cs_short;

  assign cs_short = cfg_eff[8 + BCR_B1_POWER_SAVE] && cpu_slow;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= 7'h00;
    end else if (!access_active || phase_reg == BCR_CS_SLOW_PHASES) begin
      phase_reg <= 7'h00;
    end else begin
      phase_reg <= phase_reg + 7'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chip_select_first_n <= 1'b1;
    end else if (cs_short) begin
      chip_select_first_n <= !(access_active && phase_reg == 7'h00);
    end else begin
      chip_select_first_n <= !access_active;
    end
  end

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  always_comb begin
    bus_mode_sel = {cfg_eff[8 + BCR_B1_PIN_MODE_HI],
                    cfg_eff[8 + BCR_B1_MULTI_PIN]};
    multi_pin_port_mode = (bus_mode_sel == 2'h3) ||
                          (cfg_eff[16 + BCR_B2_TEST_TOG] && active_mode &&
                           second_test_pin);
    program_access_16 = cfg_eff[16 + BCR_B2_ACC_WIDTH];
    dual_chip_select = cfg_eff[8 + BCR_B1_DUAL_CS];
    second_cs_used = dual_chip_select &&
                     !cfg_eff[8 + BCR_B1_POWER_SAVE];
    bus_pins_pulldown = cfg_eff[8 + BCR_B1_POWER_SAVE];
    bus_16bit = wide16;
    bus_async = cfg_eff[8 + BCR_B1_ASYNC];
    latch_transparent = !bus_async;
    data_drive_always = !cfg_eff[8 + BCR_B1_FULL_TRACE];
    trace_enable = !cfg_eff[8 + BCR_B1_TRACE_OFF];
    trace_grounded = !trace_enable && !data_drive_always;
    trace_analyzer = !trace_enable && data_drive_always;
    map_boot_zero = cfg_eff[BCR_B0_MAP_HI];
    map_rom_zero = !cfg_eff[BCR_B0_MAP_HI] && cfg_eff[BCR_B0_MAP_LO];
    map_ram_zero = !cfg_eff[BCR_B0_MAP_HI] && !cfg_eff[BCR_B0_MAP_LO];
    boot_internal = cfg_eff[BCR_B0_INTERNAL_BOOT_SEL];
    boot_disabled = !boot_internal && bus_mode_sel == 2'h3;
    boot_external = !boot_internal && !boot_disabled;
    program_internal = cfg_eff[BCR_B0_IPROG];
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_load_window: assert property (
    @(posedge hclk) disable iff (!hresetn)
    boot_mem_req |-> boot_mem_addr >= BCR_BOOT_ADDR_FIRST &&
                     boot_mem_addr <= BCR_BOOT_ADDR_LAST)
    else $error("boot fetch outside startup bytes");

  a_upper_fixed: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ($rose(core_run) && wide16) |-> cfg_eff[31:16] == BCR_UPPER_FIXED)
    else $error("upper half not fixed value in 16-bit mode");

  a_timer_halt: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (debug_mode && cfg_eff[16 + BCR_B2_HALT])
      |=> debug_timer_halt)
    else $error("timers not halted in debug");

  a_forced_bits: assert property (
    @(posedge hclk) disable iff (!hresetn)
    bus_16bit |-> program_access_16 && cfg_eff[16 + BCR_B2_HALT] &&
                  cfg_eff[16 + BCR_B2_PULSE_LEN] &&
                  !cfg_eff[16 + BCR_B2_TEST_TOG])
    else $error("16-bit mode forcing missing");

  sequence s_slow_cs;
    cs_short && access_active && !chip_select_first_n;
  endsequence

  a_cs_slow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_slow_cs ##1 (cs_short && access_active) [*2]
      |-> chip_select_first_n)
    else $error("first select too long in slow mode");

  a_cs_full: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!cfg_eff[8 + BCR_B1_POWER_SAVE] && access_active) ##1
    (!cfg_eff[8 + BCR_B1_POWER_SAVE] && access_active)
      |-> !chip_select_first_n)
    else $error("first select dropped during access");

  a_core_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(core_run) |-> $past(boot_mem_ack))
    else $error("core released before load finished");

  a_latch_sync: assert property (
    @(posedge hclk) disable iff (!hresetn)
    latch_transparent != bus_async)
    else $error("latch mode does not follow timing mode");

  a_write_drop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_reg && !core_run && !(boot_mem_req && boot_mem_ack))
      |=> $stable(cfg_reg))
    else $error("bus write changed config during load");

endmodule : bcr_top

// ==== dv/bcr_boot_mem.sv ====
// boot byte memory model answering the startup fetches
`timescale 1ns/1ps
module bcr_boot_mem (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic boot_mem_req,
  input wire logic [7:0] boot_mem_addr,
  output logic [7:0] boot_mem_data,
  output logic boot_mem_ack,
  input wire logic [31:0] mem_word,
  input wire logic [7:0] ack_delay,
  output logic [2:0] fetch_count
);
  logic [7:0] wait_cnt;

  // ---------------------------------------------------------------
  // byte answer after a chosen wait, data line scrambled otherwise
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_mem_ack <= 1'b0;
      boot_mem_data <= 8'hA5;
      wait_cnt <= 8'h00;
      fetch_count <= 3'h0;
    end else if (boot_mem_req && !boot_mem_ack && wait_cnt >= ack_delay) begin
      boot_mem_ack <= 1'b1;
      boot_mem_data <= mem_word[{boot_mem_addr[1:0], 3'b000} +: 8];
      wait_cnt <= 8'h00;
      fetch_count <= fetch_count + 3'h1;
    end else begin
      boot_mem_ack <= 1'b0;
      boot_mem_data <= ~boot_mem_data;
      wait_cnt <= boot_mem_req ? wait_cnt + 8'h01 : 8'h00;
    end
  end
endmodule : bcr_boot_mem

// ==== dv/boot_config_register_tb.sv ====
// self-checking bench of the boot configuration register
`timescale 1ns/1ps
module boot_config_register_tb
  import bcr_pkg::*;
;
  typedef struct packed {
    logic [31:0] word;
    logic tpin;
    logic [7:0] dly;
    logic [23:0] rd;
    logic [18:0] dec;
    logic [2:0] nfetch;
  } bcr_row_t;

  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, mem_word;
  logic [1:0] htrans, bus_mode_sel;
  logic [2:0] hsize, fetch_count;
  logic [7:0] boot_mem_addr, boot_mem_data, ack_delay;
  logic boot_mem_req, boot_mem_ack, core_run, int_reset_req, test_pin;
  logic reset_out_n, debug_mode, debug_timer_halt, active_mode;
  logic second_test_pin, multi_pin_port_mode, program_access_16;
  logic dual_chip_select, second_cs_used, cpu_slow, access_active;
  logic chip_select_first_n, bus_pins_pulldown, bus_16bit, bus_async;
  logic latch_transparent, data_drive_always, trace_enable;
  logic trace_grounded, trace_analyzer, map_ram_zero, map_rom_zero;
  logic map_boot_zero, boot_internal, boot_external, boot_disabled;
  logic program_internal;
  logic [18:0] dec_seen;
  int num_errors = 0;
  int checks = 0;
  bcr_row_t rows [4];

  assign hready = hreadyout;
  assign dec_seen = {dual_chip_select, second_cs_used, bus_16bit, bus_async,
    latch_transparent, data_drive_always, trace_enable, trace_grounded,
    trace_analyzer, map_ram_zero, map_rom_zero, map_boot_zero, boot_internal,
    boot_external, boot_disabled, program_internal, program_access_16,
    bus_pins_pulldown, multi_pin_port_mode};

  bcr_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .boot_mem_addr,
    .boot_mem_req, .boot_mem_data, .boot_mem_ack, .core_run, .int_reset_req,
    .test_pin, .reset_out_n, .debug_mode, .debug_timer_halt, .active_mode,
    .second_test_pin, .bus_mode_sel, .multi_pin_port_mode, .program_access_16,
    .dual_chip_select, .second_cs_used, .cpu_slow, .access_active,
    .chip_select_first_n, .bus_pins_pulldown, .bus_16bit, .bus_async,
    .latch_transparent, .data_drive_always, .trace_enable, .trace_grounded,
    .trace_analyzer, .map_ram_zero, .map_rom_zero, .map_boot_zero,
    .boot_internal, .boot_external, .boot_disabled, .program_internal);

  bcr_boot_mem mem (.hclk, .hresetn, .boot_mem_req, .boot_mem_addr,
    .boot_mem_data, .boot_mem_ack, .mem_word, .ack_delay, .fetch_count);

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic ahb_xfer(input logic [31:0] a, input logic wr,
                          input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb_xfer

  task automatic apply_reset(input bcr_row_t r);
    @(posedge hclk);
    hresetn <= 1'b0;
    mem_word <= r.word;
    test_pin <= r.tpin;
    ack_delay <= r.dly;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
  endtask : apply_reset

  // low cycles of the reset output, with a stray request mid-pulse
  task automatic measure(output int n);
    int k;
    n = 0;
    for (k = 0; k < 3000; k++) begin
      #1;
      if (reset_out_n === 1'b0) n++;
      else if (n > 0) break;
      @(posedge hclk);
      int_reset_req <= (n == 3);
    end
  endtask : measure

  task automatic wait_run();
    int k;
    for (k = 0; k < 200 && core_run !== 1'b1; k++) @(posedge hclk);
    check("core_run", core_run, 1'b1);
  endtask : wait_run

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int i, j, n;
    logic [31:0] d;
    {hresetn, hsel, hwrite, int_reset_req, test_pin, debug_mode} = '0;
    {active_mode, second_test_pin, access_active} = '0;
    cpu_slow = 1'b1;
    haddr = '0;
    hwdata = '0;
    htrans = 2'h0;
    hsize = 3'h2;
    mem_word = '0;
    ack_delay = '0;
    rows[0] = {32'h5AC0_800C, 1'b1, 8'h00, 24'hC0_800C,
               19'b1100111001001001000, 3'h4};
    rows[1] = {32'h0005_7610, 1'b1, 8'h05, 24'h05_7610,
               19'b0001000100100100110, 3'h4};
    rows[2] = {32'h0004_3D20, 1'b1, 8'h00, 24'hFB_3D20,
               19'b0011010010010100110, 3'h2};
    rows[3] = {32'h0000_0300, 1'b0, 8'h03, 24'h00_0300,
               19'b0000111001000010001, 3'h4};
    for (i = 0; i < 4; i++) begin
      apply_reset(rows[i]);
      measure(n);
      check("power_on_pulse", n, rows[i].tpin ? 8 : 2048);
      wait_run();
      check("fetches", fetch_count, rows[i].nfetch);
      for (j = 0; j < 3; j++) begin
        ahb_xfer(32'(j * 4), 1'b0, 32'h0, d);
        check("cfg_byte", d, {24'h0, rows[i].rd[8*j +: 8]});
      end
      check("dec_a", dec_seen[18:16], rows[i].dec[18:16]);
      check("dec_b", dec_seen[15:10], rows[i].dec[15:10]);
      check("dec_c", dec_seen[9:4], rows[i].dec[9:4]);
      check("dec_d", dec_seen[3:0], rows[i].dec[3:0]);
      check("bus_mode_sel", bus_mode_sel, rows[i].rd[9:8]);
      debug_mode <= 1'b1;
      repeat (2) @(posedge hclk);
      #1;
      check("timer_halt", debug_timer_halt, rows[i].rd[23]);
      @(posedge hclk);
      debug_mode <= 1'b0;
      active_mode <= 1'b1;
      second_test_pin <= 1'b1;
      @(posedge hclk);
      #1;
      check("port_mode", multi_pin_port_mode,
            rows[i].dec[0] | rows[i].rd[18]);
      check("timer_run", debug_timer_halt, 1'b0);
      @(posedge hclk);
      active_mode <= 1'b0;
      second_test_pin <= 1'b0;
      access_active <= 1'b1;
      repeat (2) @(posedge hclk);
      n = 0;
      repeat (256) begin
        @(posedge hclk);
        #1;
        if (chip_select_first_n === 1'b0) n++;
      end
      check("cs_low_cycles", n, rows[i].dec[1] ? 2 : 256);
      @(posedge hclk);
      access_active <= 1'b0;
      @(posedge hclk);
      int_reset_req <= 1'b1;
      measure(n);
      check("int_pulse", n,
            (rows[i].tpin && rows[i].rd[22]) ? 8 : 2048);
    end
    // writes during the load are dropped
    rows[0].dly = 8'd20;
    apply_reset(rows[0]);
    ahb_xfer(32'h4, 1'b1, 32'hFF, d);
    check("core_held", core_run, 1'b0);
    wait_run();
    ahb_xfer(32'h4, 1'b0, 32'h0, d);
    check("early_write", d, 32'h80);
    // width flag written: forcing seen on the debug byte
    ahb_xfer(32'h4, 1'b1, 32'hFFFFFF28, d);
    ahb_xfer(32'h4, 1'b0, 32'h0, d);
    check("bus_byte", d, 32'h28);
    ahb_xfer(32'h8, 1'b0, 32'h0, d);
    check("forced_bits", d, 32'hC1);
    check("bus_16bit", bus_16bit, 1'b1);
    // unmapped place and reserved byte
    ahb_xfer(32'h10, 1'b1, 32'h55, d);
    ahb_xfer(32'hC, 1'b1, 32'h77, d);
    ahb_xfer(32'h10, 1'b0, 32'h0, d);
    check("unmapped_read", d, 32'h0);
    ahb_xfer(32'h0, 1'b0, 32'h0, d);
    check("select_kept", d, 32'h0C);
    ahb_xfer(32'hC, 1'b0, 32'h0, d);
    check("spare_kept", d, 32'h5A);
    check("hresp", hresp, 1'b0);
    give_verdict();
  end
endmodule : boot_config_register_tb
